// file: design/ook_modem_consts.vh
`ifndef OOK_MODEM_CONSTS_VH
`define OOK_MODEM_CONSTS_VH

// ****************************************************************
// Clock and bit timing
// ****************************************************************
`define CLK_HZ 125000000
`define RATE_A_BPS 9600
`define RATE_B_BPS 38400
`define RATE_C_BPS 115200
`define BIT_A_CYC 14'h32dc
`define BIT_B_CYC 14'h0cb7
`define BIT_C_CYC 14'h043d
`define DIR_DWELL_BITS 5'h10
`define SCAN_FAST_BITS 12'h001
`define SCAN_SLOW_BITS 12'h010
`define SCAN_CUSTOM_RST 12'h050

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CONFIG 7'h00
`define REG_SCAN 7'h01
`define REG_DWELL_LO 7'h02
`define REG_DWELL_HI 7'h03
`define REG_SAMPLE 7'h04
`define REG_LINE_STATE 7'h07

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CONFIG_TX_ON 0
`define CONFIG_DRV_LSB 1
`define CONFIG_RATE_LSB 3
`define CONFIG_RST 8'h00
`define SCAN_RST 8'h00
`define ST_DIR 0
`define ST_RXLVL 1
`define ST_TXACT 2
`define ST_SAMPLE 3
`define ST_OVFL 4
`define SCAN_MANUAL 2'h0
`define SCAN_FAST 2'h1
`define SCAN_SLOW 2'h2
`define SCAN_CUSTOM 2'h3

// ****************************************************************
// Pin synchroniser layout
// ****************************************************************
`define PIN_SCLK 0
`define PIN_CS_N 1
`define PIN_MOSI 2
`define PIN_CARR 3
`define PIN_KEY_N 4
`define PIN_OSC 5
`define PIN_RST 6'h12
`define SPI_FRAME_BITS 5'h10
`define SPI_CMD_BITS 5'h08

`endif

// file: design/sample_fifo.v
`timescale 1ns/100ps
`include "ook_modem_consts.vh"

module sample_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // One extra pointer bit tells a full ring from an empty one.
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign push = in_valid_i & ~full;
  assign pop = out_ready_i & ~empty;
  assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule

// file: design/ook_modem_direction_scan_ctrl.v
`timescale 1ns/100ps
`include "ook_modem_consts.vh"

module ook_modem_direction_scan_ctrl #(
  parameter [13:0] BIT_A_CYC = `BIT_A_CYC,
  parameter [13:0] BIT_B_CYC = `BIT_B_CYC,
  parameter [13:0] BIT_C_CYC = `BIT_C_CYC
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  output wire miso_o,
  output wire miso_oe_o,
  input wire carrier_det_i,
  input wire transmit_key_input_n_i,
  input wire osc_clk_i,
  output wire carrier_tx_o,
  output wire dir_o,
  output wire received_level_output_o,
  output wire [1:0] port_sel_o,
  output wire shared_clock_output_o,
  output wire shared_clock_oe_o,
  output wire [1:0] clock_out_drive_sel_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function [13:0] bit_period;
    input [1:0] rate;
    begin
      case (rate)
        2'h1: bit_period = BIT_B_CYC;
        2'h2: bit_period = BIT_C_CYC;
        default: bit_period = BIT_A_CYC;
      endcase
    end
  endfunction

  // Returns the scan dwell in bit periods minus one.
  function [11:0] scan_limit;
    input [1:0] mode;
    input [11:0] custom;
    begin
      case (mode)
        `SCAN_FAST: scan_limit = `SCAN_FAST_BITS - 12'h001;
        `SCAN_SLOW: scan_limit = `SCAN_SLOW_BITS - 12'h001;
        `SCAN_CUSTOM: scan_limit = custom;
        default: scan_limit = 12'h000;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [5:0] pin_s1_reg;
  reg [5:0] pin_s2_reg;
  reg [5:0] pin_s3_reg;
  reg [5:0] pin_reg;
  wire [5:0] pin_raw;
  wire [5:0] pin_agree;

  assign pin_raw = {osc_clk_i, transmit_key_input_n_i, carrier_det_i,
                    mosi_i, cs_n_i, sclk_i};
  assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);

  // A pin change is taken only once stages two and three agree, which
  // filters a single-cycle glitch that slipped past the first stage.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_s1_reg <= `PIN_RST;
      pin_s2_reg <= `PIN_RST;
      pin_s3_reg <= `PIN_RST;
      pin_reg <= `PIN_RST;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= (pin_agree & pin_s3_reg) | (~pin_agree & pin_reg);
    end
  end

  wire carrier;
  wire key_n;
  assign carrier = pin_reg[`PIN_CARR];
  assign key_n = pin_reg[`PIN_KEY_N];

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] config_reg;
  reg [7:0] scan_reg;
  reg [11:0] custom_dwell_reg;
  reg overflow_reg;
  reg dir_reg;
  reg [1:0] port_reg;
  reg shared_clk_reg;
  wire tx_on;
  wire [1:0] drive_sel;
  wire [1:0] rate_sel;
  wire [1:0] scan_mode;
  wire sending;
  wire rx_level;
  wire [7:0] line_state;

  assign tx_on = config_reg[`CONFIG_TX_ON];
  assign drive_sel = config_reg[`CONFIG_DRV_LSB+1:`CONFIG_DRV_LSB];
  assign rate_sel = config_reg[`CONFIG_RATE_LSB+1:`CONFIG_RATE_LSB];
  assign scan_mode = scan_reg[1:0];

  assign sending = tx_on | ~key_n;
  assign rx_level = dir_reg ? ~carrier : 1'b1;

  // ****************************************************************
  // Outputs to the pins
  // ****************************************************************
  assign carrier_tx_o = sending;
  assign dir_o = dir_reg;
  assign received_level_output_o = rx_level;
  assign port_sel_o = port_reg;
  assign clock_out_drive_sel_o = drive_sel;
  assign shared_clock_oe_o = (drive_sel != 2'h0);
  assign shared_clock_output_o = shared_clk_reg;

  // The forwarded clock is a resampled copy, so it carries up to one
  // core period of jitter; slaves needing a clean edge should take the
  // crystal directly.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      shared_clk_reg <= 1'b0;
    end else begin
      shared_clk_reg <= shared_clock_oe_o & pin_reg[`PIN_OSC];
    end
  end

  // ****************************************************************
  // Bit period tick
  // ****************************************************************
  reg [13:0] bit_cnt_reg;
  wire bit_tick;

  assign bit_tick = (bit_cnt_reg >= bit_period(rate_sel) - 14'h0001);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      bit_cnt_reg <= 14'h0000;
    end else if (bit_tick) begin
      bit_cnt_reg <= 14'h0000;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 14'h0001;
    end
  end

  // ****************************************************************
  // Direction dwell
  // ****************************************************************
  reg [4:0] dir_dwell_reg;

  // Carrier seen while keying is our own echo, so it never turns the
  // line around.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      dir_reg <= 1'b0;
      dir_dwell_reg <= 5'h00;
    end else if (carrier && !sending) begin
      dir_reg <= 1'b1;
      dir_dwell_reg <= 5'h00;
    end else if (dir_reg && bit_tick) begin
      if (dir_dwell_reg == `DIR_DWELL_BITS - 5'h01) begin
        dir_reg <= 1'b0;
        dir_dwell_reg <= 5'h00;
      end else begin
        dir_dwell_reg <= dir_dwell_reg + 5'h01;
      end
    end
  end

  // ****************************************************************
  // Port scanner
  // ****************************************************************
  reg [11:0] scan_cnt_reg;

  // Stepping pauses while the direction is high so the port that
  // carries the message stays selected until it has timed out.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_reg <= 2'h0;
      scan_cnt_reg <= 12'h000;
    end else if (scan_mode == `SCAN_MANUAL) begin
      port_reg <= scan_reg[3:2];
      scan_cnt_reg <= 12'h000;
    end else if (bit_tick && !dir_reg) begin
      if (scan_cnt_reg >= scan_limit(scan_mode, custom_dwell_reg)) begin
        scan_cnt_reg <= 12'h000;
        port_reg <= port_reg + 2'h1;
      end else begin
        scan_cnt_reg <= scan_cnt_reg + 12'h001;
      end
    end
  end

  // ****************************************************************
  // Receive sample buffer
  // ****************************************************************
  wire sample_ready;
  wire sample_valid;
  wire [7:0] sample_data;
  wire sample_push;
  reg sample_pop_reg;

  assign sample_push = dir_reg & bit_tick;

  sample_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_sample_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(sample_push),
    .in_ready_o(sample_ready),
    .in_data_i({4'h0, dir_reg, port_reg, rx_level}),
    .out_valid_o(sample_valid),
    .out_ready_i(sample_pop_reg),
    .out_data_o(sample_data)
  );

  assign line_state = {3'h0, overflow_reg, sample_valid, sending,
                       rx_level, dir_reg};

  // ****************************************************************
  // Serial register port
  // ****************************************************************
  reg sclk_q_reg;
  reg [4:0] spi_cnt_reg;
  reg [15:0] spi_in_reg;
  reg [7:0] spi_out_reg;
  reg [7:0] rd_data;
  wire cs_active;
  wire sclk_rise;
  wire sclk_fall;
  wire [15:0] shifted;
  wire [6:0] cmd_addr;
  wire cmd_read;
  wire cmd_done;
  wire frame_done;

  assign cs_active = ~pin_reg[`PIN_CS_N];
  assign sclk_rise = pin_reg[`PIN_SCLK] & ~sclk_q_reg;
  assign sclk_fall = ~pin_reg[`PIN_SCLK] & sclk_q_reg;
  assign shifted = {spi_in_reg[14:0], pin_reg[`PIN_MOSI]};
  assign cmd_addr = shifted[6:0];
  assign cmd_read = shifted[7];
  assign cmd_done = cs_active & sclk_rise &
                    (spi_cnt_reg == `SPI_CMD_BITS - 5'h01);
  assign frame_done = cs_active & sclk_rise &
                      (spi_cnt_reg == `SPI_FRAME_BITS - 5'h01);
  assign miso_o = spi_out_reg[7];
  assign miso_oe_o = cs_active;

  always @* begin
    case (cmd_addr)
      `REG_CONFIG: rd_data = config_reg;
      `REG_SCAN: rd_data = scan_reg;
      `REG_DWELL_LO: rd_data = custom_dwell_reg[7:0];
      `REG_DWELL_HI: rd_data = {4'h0, custom_dwell_reg[11:8]};
      `REG_SAMPLE: rd_data = sample_valid ? sample_data : 8'h00;
      `REG_LINE_STATE: rd_data = line_state;
      default: rd_data = 8'h00;
    endcase
  end

  // Mode 0 framing: data is taken on the rising edge, the reply moves
  // on the falling edge, and raising chip select aborts a short frame.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_q_reg <= 1'b0;
      spi_cnt_reg <= 5'h00;
      spi_in_reg <= 16'h0000;
      spi_out_reg <= 8'h00;
      sample_pop_reg <= 1'b0;
    end else begin
      sclk_q_reg <= pin_reg[`PIN_SCLK];
      sample_pop_reg <= 1'b0;
      if (!cs_active) begin
        spi_cnt_reg <= 5'h00;
        spi_out_reg <= 8'h00;
      end else if (sclk_rise) begin
        spi_in_reg <= shifted;
        spi_cnt_reg <= frame_done ? 5'h00 : spi_cnt_reg + 5'h01;
        if (cmd_done && cmd_read) begin
          spi_out_reg <= rd_data;
          sample_pop_reg <= (cmd_addr == `REG_SAMPLE) & sample_valid;
        end
      end else if (sclk_fall && spi_cnt_reg > `SPI_CMD_BITS) begin
        spi_out_reg <= {spi_out_reg[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Register writes and sticky status
  // ****************************************************************
  wire wr_en;
  wire [6:0] wr_addr;
  wire status_read;

  assign wr_en = frame_done & ~spi_in_reg[14];
  assign wr_addr = spi_in_reg[13:7];
  assign status_read = cmd_done & cmd_read & (cmd_addr == `REG_LINE_STATE);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      config_reg <= `CONFIG_RST;
      scan_reg <= `SCAN_RST;
      custom_dwell_reg <= `SCAN_CUSTOM_RST;
    end else if (wr_en) begin
      case (wr_addr)
        `REG_CONFIG: config_reg <= shifted[7:0];
        `REG_SCAN: scan_reg <= {4'h0, shifted[3:0]};
        `REG_DWELL_LO: custom_dwell_reg[7:0] <= shifted[7:0];
        `REG_DWELL_HI: custom_dwell_reg[11:8] <= shifted[3:0];
        default: config_reg <= config_reg;
      endcase
    end
  end

  // A sample lost to a full buffer is flagged; a new loss in the same
  // cycle as the status read keeps the flag set.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      overflow_reg <= 1'b0;
    end else if (sample_push && !sample_ready) begin
      overflow_reg <= 1'b1;
    end else if (status_read) begin
      overflow_reg <= 1'b0;
    end
  end

endmodule

// file: dv/modem_chk_sva.sv
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module modem_chk #(
  parameter [13:0] BIT_A_CYC = 14'h0014
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cs_n_i,
  input wire miso_oe_o,
  input wire carrier_det_i,
  input wire transmit_key_input_n_i,
  input wire osc_clk_i,
  input wire carrier_tx_o,
  input wire dir_o,
  input wire received_level_output_o,
  input wire [1:0] port_sel_o,
  input wire shared_clock_output_o,
  input wire shared_clock_oe_o,
  input wire [1:0] clock_out_drive_sel_o
);
  // Dwell bounds assume the slowest rate; the bench keeps that rate selected.
  localparam int DW_MIN = 15 * BIT_A_CYC;
  localparam int DW_MAX = 16 * BIT_A_CYC + 8;
  reg [15:0] quiet_reg;
  always @(posedge clk_i) begin
    if (sys_rst_i || carrier_det_i) quiet_reg <= 16'h0000;
    else quiet_reg <= quiet_reg + {15'h0000, quiet_reg != 16'hffff};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_clk_oe; shared_clock_oe_o == (clock_out_drive_sel_o != 2'h0); endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable wrong");
  property p_clk_off;
    (clock_out_drive_sel_o == 2'h0 && $past(clock_out_drive_sel_o) == 2'h0)
      |-> !shared_clock_output_o;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock out not off");
  property p_clk_fwd;
    (clock_out_drive_sel_o != 2'h0 && $stable(osc_clk_i))[*6]
      |-> shared_clock_output_o == osc_clk_i;
  endproperty
  a_clk_fwd: assert property (p_clk_fwd) else $error("clock not forwarded");
  property p_rx_idle; !dir_o |-> received_level_output_o; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive low while idle");
  property p_dir_rise; $rose(dir_o) |-> $past(carrier_det_i, 4); endproperty
  a_dir_rise: assert property (p_dir_rise) else $error("direction rose alone");
  property p_dir_fall; $fell(dir_o) |-> quiet_reg >= DW_MIN; endproperty
  a_dir_fall: assert property (p_dir_fall) else $error("direction fell early");
  property p_dir_max; dir_o |-> quiet_reg <= DW_MAX; endproperty
  a_dir_max: assert property (p_dir_max) else $error("direction held too long");
  property p_key; !transmit_key_input_n_i [*6] |-> carrier_tx_o; endproperty
  a_key: assert property (p_key) else $error("key pin not keying");
  property p_oe; cs_n_i [*6] |-> !miso_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("data out driven unselected");
  property p_scan; dir_o && $past(dir_o) |-> $stable(port_sel_o); endproperty
  a_scan: assert property (p_scan) else $error("port moved while receiving");
endmodule

bind ook_modem_direction_scan_ctrl modem_chk #(.BIT_A_CYC(BIT_A_CYC)) chk_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .miso_oe_o(miso_oe_o),
  .carrier_det_i(carrier_det_i), .transmit_key_input_n_i(transmit_key_input_n_i),
  .osc_clk_i(osc_clk_i), .carrier_tx_o(carrier_tx_o), .dir_o(dir_o),
  .received_level_output_o(received_level_output_o), .port_sel_o(port_sel_o),
  .shared_clock_output_o(shared_clock_output_o), .shared_clock_oe_o(shared_clock_oe_o),
  .clock_out_drive_sel_o(clock_out_drive_sel_o));

// file: dv/spi_host_model.sv
`timescale 1ns/100ps
// ****************
// Host register port
// ****************
module spi_host_model (
  input wire clk_i,
  input wire miso_i,
  output reg sclk_o,
  output reg cs_n_o,
  output reg mosi_o,
  output reg done_o,
  output reg [7:0] rdata_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
    done_o = 1'b0;
    rdata_o = 8'h00;
  end
  // Eight core clocks per phase keeps the serial clock just under 8 MHz.
  task automatic half;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic xfer(input [15:0] word);
    integer i;
    begin
      cs_n_o <= 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        half;
        sclk_o <= 1'b0;
        mosi_o <= word[i];
        half;
        sclk_o <= 1'b1;
        if (i < 8) rdata_o[i] <= miso_i;
      end
      half;
      sclk_o <= 1'b0;
      half;
      // A released data line shows the inverse so a stale level is never trusted.
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      done_o <= word[15];
      @(posedge clk_i);
      done_o <= 1'b0;
      half;
    end
  endtask
endmodule

// file: dv/ook_modem_direction_scan_ctrl_test.sv
`timescale 1ns/100ps
// ****************
// Bench
// ****************
module ook_modem_direction_scan_ctrl_test;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg car = 1'b0;
  reg key_n = 1'b1;
  reg osc = 1'b0;
  reg [2:0] oc = 3'h0;
  wire sclk, cs_n, mosi, miso, done, ctx, dir, rxl, sco, scoe;
  wire [1:0] port, dsel;
  wire [7:0] rdata;
  integer n_errors = 0, checks = 0, seed = 32'hd4b7ecaf, i, t;
  reg [15:0] q[$];
  reg [15:0] e;
  reg [7:0] r;
  reg [1:0] p;
  initial forever #4 clk_i = ~clk_i;
  // The oscillator is a slow stand-in; its exact rate does not matter here.
  always @(posedge clk_i) begin
    oc <= oc + 3'h1;
    if (oc == 3'h7) osc <= ~osc;
  end
  ook_modem_direction_scan_ctrl #(.BIT_A_CYC(14'h0014), .BIT_B_CYC(14'h000a), .BIT_C_CYC(14'h0005))
    ook_modem_direction_scan_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(), .carrier_det_i(car),
    .transmit_key_input_n_i(key_n), .osc_clk_i(osc), .carrier_tx_o(ctx), .dir_o(dir),
    .received_level_output_o(rxl), .port_sel_o(port), .shared_clock_output_o(sco),
    .shared_clock_oe_o(scoe), .clock_out_drive_sel_o(dsel));
  spi_host_model spi_host_model_inst (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi), .done_o(done), .rdata_o(rdata));
  task compare_val(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    spi_host_model_inst.xfer({1'b0, a, d});
  endtask
  task rd(input [6:0] a, input [7:0] m, input [7:0] x);
    begin
      q.push_back({m, x});
      spi_host_model_inst.xfer({1'b1, a, 8'h00});
    end
  endtask
  task wait_clk(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task step(output integer c);
    begin
      p = port;
      c = 0;
      while (port === p && c < 2000) begin
        @(posedge clk_i);
        c = c + 1;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      if (q.size() == 0) e = 16'h00ff;
      else e = q.pop_front();
      compare_val({8'h00, rdata & e[15:8]}, {8'h00, e[7:0]});
    end
  end
  initial begin
    wait_clk(60000);
    n_errors = n_errors + 1;
    final_report;
  end
  initial begin
    wait_clk(2);
    sys_rst_i <= 1'b0;
    wait_clk(8);
    rd(7'h00, 8'hff, 8'h00);
    rd(7'h02, 8'hff, 8'h50);
    rd(7'h07, 8'h07, 8'h02);
    rd(7'h05, 8'hff, 8'h00);
    wr(7'h07, 8'hff);
    rd(7'h07, 8'h07, 8'h02);
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      r = {r[7:5], 2'b00, i[1:0], 1'b0};
      wr(7'h00, r);
      compare_val({14'h0, dsel}, i);
      compare_val({15'h0, scoe}, {15'h0, i != 0});
      rd(7'h00, 8'h1f, r & 8'h1f);
    end
    $display("test clock select done");
    wr(7'h00, 8'h00);
    compare_val({15'h0, sco}, 16'h0);
    rd(7'h07, 8'h01, 8'h00);
    wr(7'h00, 8'h01);
    compare_val({15'h0, ctx}, 16'h1);
    car <= 1'b1;
    wait_clk(40);
    rd(7'h07, 8'h07, 8'h06);
    car <= 1'b0;
    wr(7'h00, 8'h00);
    compare_val({15'h0, ctx}, 16'h0);
    key_n <= 1'b0;
    wait_clk(8);
    compare_val({15'h0, ctx}, 16'h1);
    rd(7'h07, 8'h07, 8'h06);
    key_n <= 1'b1;
    wait_clk(8);
    compare_val({15'h0, ctx}, 16'h0);
    $display("test transmit done");
    car <= 1'b1;
    wait_clk(40);
    compare_val({14'h0, dir, rxl}, 16'h2);
    rd(7'h07, 8'h07, 8'h01);
    car <= 1'b0;
    wait_clk(8);
    compare_val({15'h0, rxl}, 16'h1);
    rd(7'h07, 8'h07, 8'h03);
    car <= 1'b1;
    wait_clk(30);
    car <= 1'b0;
    wait_clk(200);
    car <= 1'b1;
    wait_clk(30);
    car <= 1'b0;
    wait_clk(280);
    compare_val({15'h0, dir}, 16'h1);
    wait_clk(60);
    compare_val({15'h0, dir}, 16'h0);
    $display("test direction done");
    rd(7'h07, 8'h18, 8'h18);
    for (i = 0; i < 8; i = i + 1) rd(7'h04, 8'h0e, 8'h08);
    rd(7'h04, 8'hff, 8'h00);
    rd(7'h07, 8'h18, 8'h00);
    $display("test sample buffer done");
    wr(7'h01, 8'h08);
    compare_val({14'h0, port}, 16'h2);
    wr(7'h02, 8'h02);
    for (i = 1; i < 4; i = i + 1) begin
      wr(7'h01, i);
      step(t);
      step(t);
      compare_val(t, i == 1 ? 20 : (i == 2 ? 320 : 60));
      compare_val({14'h0, port}, {14'h0, p + 2'h1});
    end
    // An incoming message must freeze the custom-dwell stepping.
    car <= 1'b1;
    wait_clk(8);
    p = port;
    wait_clk(200);
    compare_val({13'h0, dir, port}, {13'h0, 1'b1, p});
    car <= 1'b0;
    wr(7'h02, 8'hff);
    wr(7'h03, 8'h0f);
    rd(7'h03, 8'h0f, 8'h0f);
    rd(7'h02, 8'hff, 8'hff);
    $display("test scanner done");
    wait_clk(10);
    final_report;
  end
endmodule
